/* rtl/pci_arb_defs.svh */
`ifndef PCI_ARB_DEFS_SVH
`define PCI_ARB_DEFS_SVH

// ---------------------------------------------------------------
// Sizes and idle levels
// ---------------------------------------------------------------
`define PCI_ARB_AGENTS 4
`define PCI_ARB_IDLE_N 4'hf
`define PCI_ARB_SYNC_STAGES 3
`endif

/* rtl/pci_arb_pkg.sv */
package pci_arb_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_GRANT = 2'b01,
        ST_PARK = 2'b10
    } arb_state_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } pin_drive_t;
endpackage : pci_arb_pkg

/* rtl/pci_arb_sync.sv */
`timescale 1ns/100ps
`include "pci_arb_defs.svh"
// Three-stage sampler; a change counts once stages two and three agree.
module pci_arb_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            o_sync <= INIT;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    o_sync[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : pci_arb_sync

/* rtl/pci_arb_pins.sv */
`timescale 1ns/100ps
`include "pci_arb_defs.svh"
module pci_arb_pins
    import pci_arb_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Mode
    input wire logic i_arb_enable,
    // Bus clock from the far side
    input wire logic i_bus_clock_input,
    // Request pins, active low; line 0 is two-way
    input wire logic [3:0] i_req_n,
    output logic o_req0_n,
    output logic o_req0_oe,
    // Grant pins, active low; line 0 is two-way
    input wire logic i_gnt0_n,
    output logic [3:0] o_gnt_n,
    output logic [3:0] o_gnt_oe,
    // Internal master side
    input wire logic i_own_req,
    output logic o_own_gnt,
    output logic [3:0] o_owner
);
    // ---------------------------------------------------------------
    // Input sampling
    // ---------------------------------------------------------------
    logic clk_s;
    logic clk_prev_q;
    logic [3:0] req_s;
    logic gnt0_s;
    logic bus_edge;

    // Every pin comes from the far side, so each crosses through the
    // sampler. The bus clock is found by its edges, which only works
    // while the core clock runs well above twice the bus clock.

    // Sampler starts at the idle level of every pin: all lines high
    pci_arb_sync #(.WIDTH(6), .INIT({2'b11, `PCI_ARB_IDLE_N})) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_bus_clock_input, i_gnt0_n, i_req_n}),
        .o_sync({clk_s, gnt0_s, req_s})
    );

    // ---------------------------------------------------------------
    // Bus clock edge detection
    // ---------------------------------------------------------------
    // Starts high like the sampler, so leaving reset is no false edge
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            clk_prev_q <= 1'b1;
        end else begin
            clk_prev_q <= clk_s;
        end
    end

    // Pins change on bus clock rising edges, except when i_arb_enable changes
    assign bus_edge = clk_s & ~clk_prev_q;

    // ---------------------------------------------------------------
    // Arbitration (round robin, one grant at a time)
    // ---------------------------------------------------------------
    arb_state_t state_q;
    logic [3:0] gnt_q;
    logic [1:0] last_q;
    logic [3:0] req_act;
    logic own_gnt_q;
    logic req0_drv_q;

    // ---------------------------------------------------------------
    // Round-robin helpers
    // ---------------------------------------------------------------
    // Search starts just after the last winner, so no agent can starve
    function automatic logic [3:0] pick(input logic [3:0] req,
                                        input logic [1:0] last);
        logic [3:0] res;
        logic [1:0] idx;
        res = 4'h0;
        for (int k = 1; k <= 4; k++) begin
            idx = 2'(int'(last) + k);
            if (res == 4'h0 && req[idx]) begin
                res[idx] = 1'b1;
            end
        end
        return res;
    endfunction : pick

    // Index of the single set bit; zero when none is set
    function automatic logic [1:0] enc(input logic [3:0] oh);
        logic [1:0] r;
        r = 2'd0;
        for (int k = 0; k < 4; k++) begin
            if (oh[k]) begin
                r = 2'(k);
            end
        end
        return r;
    endfunction : enc

    // Active-high requests; line 0 counts only in arbiter mode
    assign req_act = {~req_s[3:1], ~req_s[0] & i_arb_enable};

    logic [3:0] pick_d;
    logic [1:0] last_d;
    logic [3:0] held;

    // Winner is worked out once so the grant and the pointer agree
    always_comb begin
        pick_d = pick(req_act, last_q);
        last_d = enc(pick_d);
    end

    // Requests still asserted by the agent that holds the grant
    assign held = gnt_q & req_act;

    // ---------------------------------------------------------------
    // Arbitration state
    // ---------------------------------------------------------------
    // Turning the arbiter off drops straight to idle, so no grant is
    // left standing while line 0 turns around
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
        end else if (!i_arb_enable) begin
            state_q <= ST_IDLE;
        end else if (bus_edge) begin
            case (state_q)
                ST_IDLE: begin
                    // Any request wakes the arbiter; the winner is pick_d
                    if (req_act != 4'h0) begin
                        state_q <= ST_GRANT;
                    end
                end
                ST_GRANT: begin
                    // Hold until the owner releases its request
                    if (held == 4'h0) begin
                        state_q <= ST_PARK;
                    end
                end
                ST_PARK: begin
                    // Two idle bus clocks between grants avoid overlap
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Grant register
    // ---------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gnt_q <= 4'h0;
        end else if (!i_arb_enable) begin
            gnt_q <= 4'h0;
        end else if (bus_edge) begin
            if (state_q == ST_IDLE) begin
                // The winner takes the grant, or none when nobody asks
                gnt_q <= pick_d;
            end else if (held == 4'h0 || state_q != ST_GRANT) begin
                // Withdraw the grant once its owner lets the request go
                gnt_q <= 4'h0;
            end
        end
    end

    // Pointer moves only when a grant is really issued, so idle bus
    // clocks leave the rotation where it was
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_q <= 2'd0;
        end else if (i_arb_enable && bus_edge && state_q == ST_IDLE
                     && req_act != 4'h0) begin
            last_q <= last_d;
        end
    end

    // ---------------------------------------------------------------
    // External-arbiter mode
    // ---------------------------------------------------------------
    // Line 0 asks for the bus whenever the internal master does
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            req0_drv_q <= 1'b0;
        end else if (i_arb_enable) begin
            req0_drv_q <= 1'b0;
        end else if (bus_edge) begin
            req0_drv_q <= i_own_req;
        end
    end

    // The bus counts as ours only while we still ask and the grant
    // is seen; a grant left over after the request drops is ignored
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            own_gnt_q <= 1'b0;
        end else if (i_arb_enable) begin
            own_gnt_q <= 1'b0;
        end else if (bus_edge) begin
            own_gnt_q <= i_own_req & ~gnt0_s;
        end
    end

    // ---------------------------------------------------------------
    // Pin drive
    // ---------------------------------------------------------------
    // Line 0 request is only driven with the arbiter off; otherwise
    // the pin belongs to the agent on that line
    assign o_req0_n = ~req0_drv_q;
    assign o_req0_oe = ~i_arb_enable;

    // Grant line 0 is left to the external arbiter when disabled
    assign o_gnt_n = ~gnt_q;
    assign o_gnt_oe = {3'b111, i_arb_enable};

    // Owner mirrors the grant register in active-high form
    assign o_own_gnt = own_gnt_q;
    assign o_owner = gnt_q;
endmodule : pci_arb_pins

/* verification/pci_arb_pins_assertions.sv */
`timescale 1ns/100ps
module pci_arb_pins_assertions (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_arb_enable,
    input wire logic i_bus_clock_input,
    input wire logic [3:0] i_req_n,
    input wire logic o_req0_n,
    input wire logic o_req0_oe,
    input wire logic i_gnt0_n,
    input wire logic [3:0] o_gnt_n,
    input wire logic [3:0] o_gnt_oe,
    input wire logic i_own_req,
    input wire logic o_own_gnt,
    input wire logic [3:0] o_owner
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_ask;
        $rose(i_own_req) && !i_arb_enable;
    endsequence
    chk_req0_dir: assert property (o_req0_oe == !i_arb_enable)
        else $error("req0 dir");
    chk_gnt_dir: assert property (o_gnt_oe == {3'h7, i_arb_enable})
        else $error("gnt dir");
    chk_one_gnt: assert property ($onehot0(~o_gnt_n))
        else $error("two grants");
    chk_park_gap: assert property (i_arb_enable &&
        $past(o_gnt_n) != 4'hf && o_gnt_n == 4'hf |-> (o_gnt_n == 4'hf)[*8])
        else $error("park gap");
    chk_gnt0_off: assert property (!$past(i_arb_enable) |-> o_gnt_n[0])
        else $error("gnt0 off");
    chk_gnt_asked: assert property (i_arb_enable |->
        (~o_gnt_n & $past(o_gnt_n) & $past(i_req_n, 3)) == 4'h0)
        else $error("unasked");
    chk_own_seen: assert property ($rose(o_own_gnt) |->
        !$past(i_gnt0_n, 3) && !$past(i_arb_enable)) else $error("own");
    chk_own_ask: assert property (s_ask |-> ##[1:40]
        (!o_req0_n || !i_own_req || i_arb_enable)) else $error("ask");
endmodule : pci_arb_pins_assertions
bind pci_arb_pins pci_arb_pins_assertions u_chk (.*);

/* verification/pci_bus_agents.sv */
`timescale 1ns/100ps
module pci_bus_agents (
    input wire logic i_bus_clk,
    input wire logic [3:0] i_want,
    input wire logic i_slow,
    input wire logic i_req0_n,
    input wire logic i_req0_oe,
    input wire logic i_gnt0_n,
    input wire logic i_gnt0_oe,
    output logic [3:0] o_req_n,
    output logic o_gnt0_n
);
    logic [3:0] want_q = 4'h0;
    logic gnt_q = 1'b1;
    logic seen_q = 1'b0;
    always @(posedge i_bus_clk) want_q <= i_want;
    // Slow arbiter grants one bus edge later
    always @(posedge i_bus_clk) begin
        seen_q <= i_req0_oe && !i_req0_n;
        gnt_q <= !(i_req0_oe && !i_req0_n && (seen_q || !i_slow));
    end
    // Line 0 is driven by its agent or the external arbiter whenever the chip does not drive it
    assign o_req_n = {~want_q[3:1], i_req0_oe ? i_req0_n : ~want_q[0]};
    assign o_gnt0_n = i_gnt0_oe ? i_gnt0_n : gnt_q;
endmodule : pci_bus_agents

/* verification/tb.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
`define WAIT(c) for (int w = 0; w < 100 && !(c); w++) @(posedge clk);
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic bus_clk = 1'b0;
    logic en = 1'b1;
    logic own_req = 1'b0;
    logic slow = 1'b0;
    logic [3:0] want = 4'h0;
    logic [3:0] req_n, gnt_n, gnt_oe, owner;
    logic req0_n, req0_oe, gnt0_n, own_gnt;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    always #160 bus_clk = ~bus_clk;
    pci_arb_pins u_pci_arb_pins (.i_core_clk(clk), .i_rst_b(rst_b),
        .i_arb_enable(en), .i_bus_clock_input(bus_clk), .i_req_n(req_n),
        .o_req0_n(req0_n), .o_req0_oe(req0_oe), .i_gnt0_n(gnt0_n),
        .o_gnt_n(gnt_n), .o_gnt_oe(gnt_oe), .i_own_req(own_req),
        .o_own_gnt(own_gnt), .o_owner(owner));
    pci_bus_agents u_pci_bus_agents (.i_bus_clk(bus_clk), .i_want(want),
        .i_slow(slow), .i_req0_n(req0_n), .i_req0_oe(req0_oe),
        .i_gnt0_n(gnt_n[0]), .i_gnt0_oe(gnt_oe[0]), .o_req_n(req_n),
        .o_gnt0_n(gnt0_n));
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task test_each_grant;
        for (int k = 0; k < 4; k++) begin
            want = 4'h1 << k;
            `WAIT(gnt_n[k] === 1'b0)
            #1;
            `CHK("gnt", ~(4'h1 << k), gnt_n)
            `CHK("owner", 4'h1 << k, owner)
            want = 4'h0;
            `WAIT(gnt_n === 4'hf)
            #1;
            `CHK("free", 4'hf, gnt_n)
        end
        $display("each_grant done");
    endtask : test_each_grant
    task test_contend;
        want = 4'h6;
        `WAIT(gnt_n !== 4'hf)
        #1;
        `CHK("first", 4'hd, gnt_n)
        want = 4'h4;
        `WAIT(gnt_n === 4'hb)
        #1;
        `CHK("second", 4'hb, gnt_n)
        want = 4'h0;
        `WAIT(gnt_n === 4'hf)
        #1;
        `CHK("released", 4'hf, gnt_n)
        $display("contend done");
    endtask : test_contend
    task test_disabled;
        #1;
        en = 1'b0;
        want = 4'h1;
        slow = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        `CHK("oe", 1'b1, req0_oe)
        `CHK("ignored", 4'hf, gnt_n)
        `CHK("idle", 1'b0, own_gnt)
        own_req = 1'b1;
        `WAIT(own_gnt === 1'b1)
        #1;
        `CHK("req0", 1'b0, req0_n)
        `CHK("own", 1'b1, own_gnt)
        own_req = 1'b0;
        `WAIT(own_gnt === 1'b0)
        #1;
        `CHK("dropped", 1'b0, own_gnt)
        // Second round against an arbiter that answers at once
        slow = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        own_req = 1'b1;
        `WAIT(own_gnt === 1'b1)
        #1;
        `CHK("fast own", 1'b1, own_gnt)
        `CHK("fast req0", 1'b0, req0_n)
        own_req = 1'b0;
        `WAIT(own_gnt === 1'b0)
        #1;
        `CHK("fast drop", 1'b0, own_gnt)
        $display("disabled done");
    endtask : test_disabled
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_b = 1'b1;
        `CHK("reset", 4'hf, gnt_n)
        test_each_grant();
        test_contend();
        test_disabled();
        report_and_stop();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
endmodule : tb
